// file: src/sim_pkg.sv
package sim_pkg;

    // ==========================================================
    // Register map: printed offsets are word indexes
    // ==========================================================
    localparam int unsigned SIM_ADDR_W = 12;
    localparam logic [9:0] SIM_IDX_TX0 = 10'h110;
    localparam logic [9:0] SIM_IDX_TX1 = 10'h111;
    localparam logic [9:0] SIM_IDX_CTL = 10'h112;
    localparam logic [9:0] SIM_IDX_FLG = 10'h113;
    localparam logic [9:0] SIM_IDX_RX0 = 10'h114;
    localparam logic [9:0] SIM_IDX_RX1 = 10'h115;

    // ==========================================================
    // Field positions and reset values
    // ==========================================================
    localparam int unsigned SIM_CTL_ID_LSB = 0;
    localparam int unsigned SIM_CTL_EN_BIT = 3;
    localparam int unsigned SIM_CTL_IE_BIT = 4;
    localparam int unsigned SIM_FLG_RX0 = 0;
    localparam int unsigned SIM_FLG_RX0_OVF = 1;
    localparam int unsigned SIM_FLG_RX1 = 2;
    localparam int unsigned SIM_FLG_RX1_OVF = 3;
    localparam int unsigned SIM_FLG_TX0 = 4;
    localparam int unsigned SIM_FLG_TX1 = 5;
    localparam int unsigned SIM_FLG_PEND = 6;
    localparam logic [7:0] SIM_BYTE_RST = 8'h00;
    localparam logic [6:0] SIM_FLG_RST = 7'h00;
    localparam logic [1:0] SIM_RESP_OKAY = 2'h0;
    localparam logic [1:0] SIM_RESP_SLVERR = 2'h2;

    // ==========================================================
    // Link constants
    // ==========================================================
    localparam logic [4:0] SIM_ADDR_FIXED = 5'h0B;
    localparam logic [3:0] SIM_BITS_PER_BYTE = 4'h8;
    localparam logic [1:0] SIM_IDX_END = 2'h2;

    typedef struct packed {
        logic irq_en;
        logic link_en;
        logic [1:0] addr_low_bits;
    } sim_ctrl_s;

    localparam sim_ctrl_s SIM_CTRL_RST = '0;

    typedef enum logic [2:0] {
        SIM_IDLE, SIM_ADDR, SIM_ADDR_ACK, SIM_RX, SIM_RX_ACK,
        SIM_TX, SIM_TX_ACK, SIM_TX_NEXT
    } sim_state_e;

endpackage

// file: src/sim_pin_sync.sv
`timescale 1ns/100ps
module sim_pin_sync
    import sim_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic scl_pin,
    input wire logic sda_pin,
    output logic scl_s,
    output logic sda_s,
    output logic scl_rise,
    output logic scl_fall,
    output logic start_det,
    output logic stop_det
);

    // ==========================================================
    // Two-stage synchronisers, bus idles high
    // ==========================================================
    logic [1:0] pin_in;
    logic [1:0] meta_q;
    logic [1:0] sync_q;
    logic [1:0] prev_q;

    assign pin_in = {sda_pin, scl_pin};

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_sync
            always_ff @(posedge clk) begin
                if (!resetn) begin
                    meta_q[g] <= 1'b1;
                    sync_q[g] <= 1'b1;
                    prev_q[g] <= 1'b1;
                end else begin
                    meta_q[g] <= pin_in[g];
                    sync_q[g] <= meta_q[g];
                    prev_q[g] <= sync_q[g];
                end
            end
        end
    endgenerate

    // ==========================================================
    // Edge and bus condition detection
    // ==========================================================
    assign scl_s = sync_q[0];
    assign sda_s = sync_q[1];
    assign scl_rise = sync_q[0] & ~prev_q[0];
    assign scl_fall = ~sync_q[0] & prev_q[0];
    // SDA moving while SCL stays high marks start or stop
    assign start_det = sync_q[0] & prev_q[0] & prev_q[1] & ~sync_q[1];
    assign stop_det = sync_q[0] & prev_q[0] & ~prev_q[1] & sync_q[1];

endmodule // sim_pin_sync

// file: src/sim_mailbox.sv
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/100ps
// Function
// [R1] Read frame: start, 01011, ID bits, one
// [R2] Low address bits from control ID field
// [R3] Interface works only while enable is set
// [R4] First read byte comes from transmit zero
// [R5] Second read byte comes from transmit one
// [R6] Transmit registers: software RW, reset zero
// [R7] Receive registers capture master bytes, reset zero
// [R8] Write bytes go to receive zero, one
// [R9] Transmit one sent sets its done flag
// [R10] Transmit zero sent sets its done flag
// [R11] Receive one overwrite sets its overflow flag
// [R12] Receive one completion sets its done flag
// [R13] Receive zero overwrite sets its overflow flag
// [R14] Receive zero completion sets its done flag
// [R15] Any event sets combined pending flag
// [R16] Interrupt while pending and interrupt enabled
// [R17] Overflow means done flag still set
// [R18] Writing zero clears pending; flags reset zero
// [R19] Disabled or mismatch: no ack, no change
// [R20] Writing one keeps flags; set beats clear
module sim_mailbox
    import sim_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic scl_pin,
    input wire logic sda_pin,
    output logic sda_o,
    output logic sda_oe,
    output logic irq,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [SIM_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [SIM_ADDR_W-1:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp
);

    // ==========================================================
    // Declarations
    // ==========================================================
    logic scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det;
    sim_state_e st_q;
    logic [3:0] bitcnt_q;
    logic [7:0] sh_q;
    logic [7:0] tx_sh_q;
    logic rw_q;
    logic [1:0] idx_q;
    logic sda_oe_q;
    logic irq_q;
    sim_ctrl_s ctrl_q;
    logic [7:0] tx0_q, tx1_q, rx0_q, rx1_q;
    logic [6:0] flags_q, flags_d, flag_set;
    logic link_ok, addr_hit, rx_store, tx_done;
    logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q;
    logic wr_fire, rd_fire;
    logic [9:0] wr_idx, rd_idx;
    logic [7:0] rd_byte;
    logic rd_hit, wr_hit;

    sim_pin_sync sim_pin_sync_inst (
        .clk(clk),
        .resetn(resetn),
        .scl_pin(scl_pin),
        .sda_pin(sda_pin),
        .scl_s(scl_s),
        .sda_s(sda_s),
        .scl_rise(scl_rise),
        .scl_fall(scl_fall),
        .start_det(start_det),
        .stop_det(stop_det)
    );

    // ==========================================================
    // Link events
    // ==========================================================
    assign link_ok = ctrl_q.link_en & ~start_det & ~stop_det;
    assign addr_hit = (sh_q[7:3] == SIM_ADDR_FIXED) // [R1]
        && (sh_q[2:1] == ctrl_q.addr_low_bits); // [R2]
    assign rx_store = link_ok && st_q == SIM_RX && scl_fall
        && bitcnt_q == SIM_BITS_PER_BYTE && idx_q != SIM_IDX_END;
    assign tx_done = link_ok && st_q == SIM_TX && scl_fall
        && bitcnt_q == SIM_BITS_PER_BYTE;

    // ==========================================================
    // Serial engine
    // ==========================================================
    always_ff @(posedge clk) begin
        if (!resetn) begin
            st_q <= SIM_IDLE;
            bitcnt_q <= 4'h0;
            sh_q <= SIM_BYTE_RST;
            tx_sh_q <= SIM_BYTE_RST;
            rw_q <= 1'b0;
            idx_q <= 2'h0;
            sda_oe_q <= 1'b0;
        end else if (!ctrl_q.link_en) begin
            st_q <= SIM_IDLE; // [R3]
            sda_oe_q <= 1'b0;
        end else if (start_det) begin
            st_q <= SIM_ADDR;
            bitcnt_q <= 4'h0;
            idx_q <= 2'h0;
            sda_oe_q <= 1'b0;
        end else if (stop_det) begin
            st_q <= SIM_IDLE;
            sda_oe_q <= 1'b0;
        end else begin
            case (st_q)
                SIM_ADDR, SIM_RX: begin
                    if (scl_rise) begin
                        sh_q <= {sh_q[6:0], sda_s};
                        bitcnt_q <= bitcnt_q + 4'h1;
                    end else if (scl_fall
                            && bitcnt_q == SIM_BITS_PER_BYTE) begin
                        if (st_q == SIM_ADDR && addr_hit) begin
                            sda_oe_q <= 1'b1; // [R1] [R2]
                            rw_q <= sh_q[0];
                            st_q <= SIM_ADDR_ACK;
                        end else if (st_q == SIM_RX
                                && idx_q != SIM_IDX_END) begin
                            sda_oe_q <= 1'b1; // [R8]
                            idx_q <= idx_q + 2'h1;
                            st_q <= SIM_RX_ACK;
                        end else begin
                            st_q <= SIM_IDLE; // [R19]
                        end
                    end
                end
                SIM_ADDR_ACK: begin
                    if (scl_fall) begin
                        bitcnt_q <= 4'h1;
                        if (rw_q) begin
                            // Data bit 7 goes out on the ack's fall
                            sda_oe_q <= ~tx0_q[7]; // [R4]
                            tx_sh_q <= {tx0_q[6:0], 1'b0};
                            st_q <= SIM_TX;
                        end else begin
                            bitcnt_q <= 4'h0;
                            sda_oe_q <= 1'b0;
                            st_q <= SIM_RX;
                        end
                    end
                end
                SIM_RX_ACK: begin
                    if (scl_fall) begin
                        sda_oe_q <= 1'b0;
                        bitcnt_q <= 4'h0;
                        st_q <= SIM_RX;
                    end
                end
                SIM_TX: begin
                    if (scl_fall) begin
                        if (bitcnt_q == SIM_BITS_PER_BYTE) begin
                            sda_oe_q <= 1'b0;
                            idx_q <= idx_q + 2'h1;
                            st_q <= SIM_TX_ACK;
                        end else begin
                            sda_oe_q <= ~tx_sh_q[7];
                            tx_sh_q <= {tx_sh_q[6:0], 1'b0};
                            bitcnt_q <= bitcnt_q + 4'h1;
                        end
                    end
                end
                SIM_TX_ACK: begin
                    // Master NACK ends the read; we wait for stop
                    if (scl_rise) begin
                        st_q <= sda_s ? SIM_IDLE : SIM_TX_NEXT;
                    end
                end
                SIM_TX_NEXT: begin
                    if (scl_fall) begin
                        if (idx_q == 2'h1) begin
                            sda_oe_q <= ~tx1_q[7]; // [R5]
                            tx_sh_q <= {tx1_q[6:0], 1'b0};
                            bitcnt_q <= 4'h1;
                            st_q <= SIM_TX;
                        end else begin
                            st_q <= SIM_IDLE;
                        end
                    end
                end
                default: begin
                    st_q <= SIM_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // AXI4-Lite slave
    // ==========================================================
    assign wr_fire = awready_q & s_axi_awvalid;
    assign rd_fire = arready_q & s_axi_arvalid;
    assign wr_idx = s_axi_awaddr[SIM_ADDR_W-1:2];
    assign rd_idx = s_axi_araddr[SIM_ADDR_W-1:2];
    assign wr_hit = wr_idx >= SIM_IDX_TX0 && wr_idx <= SIM_IDX_RX1;
    assign rd_hit = rd_idx >= SIM_IDX_TX0 && rd_idx <= SIM_IDX_RX1;

    // Address and data are taken in the same beat once both are
    // offered; a lone channel just waits, which AXI allows
    always_ff @(posedge clk) begin
        if (!resetn) begin
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= SIM_RESP_OKAY;
        end else begin
            awready_q <= s_axi_awvalid & s_axi_wvalid & ~awready_q
                & ~bvalid_q;
            wready_q <= s_axi_awvalid & s_axi_wvalid & ~awready_q
                & ~bvalid_q;
            if (wr_fire) begin
                bvalid_q <= 1'b1;
                bresp_q <= wr_hit ? SIM_RESP_OKAY : SIM_RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    always_comb begin
        case (rd_idx)
            SIM_IDX_TX0: rd_byte = tx0_q;
            SIM_IDX_TX1: rd_byte = tx1_q;
            SIM_IDX_CTL: rd_byte = {3'h0, ctrl_q.irq_en,
                ctrl_q.link_en, 1'b0, ctrl_q.addr_low_bits};
            SIM_IDX_FLG: rd_byte = {1'b0, flags_q};
            SIM_IDX_RX0: rd_byte = rx0_q;
            SIM_IDX_RX1: rd_byte = rx1_q;
            default: rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0;
            rresp_q <= SIM_RESP_OKAY;
        end else begin
            arready_q <= s_axi_arvalid & ~arready_q & ~rvalid_q;
            if (rd_fire) begin
                rvalid_q <= 1'b1;
                rdata_q <= {24'h0, rd_byte};
                rresp_q <= rd_hit ? SIM_RESP_OKAY : SIM_RESP_SLVERR;
            end else if (s_axi_rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Holding and control registers
    // ==========================================================
    always_ff @(posedge clk) begin
        if (!resetn) begin
            tx0_q <= SIM_BYTE_RST; // [R6]
            tx1_q <= SIM_BYTE_RST;
            ctrl_q <= SIM_CTRL_RST;
        end else if (wr_fire && s_axi_wstrb[0]) begin
            if (wr_idx == SIM_IDX_TX0) tx0_q <= s_axi_wdata[7:0]; // [R6]
            if (wr_idx == SIM_IDX_TX1) tx1_q <= s_axi_wdata[7:0];
            if (wr_idx == SIM_IDX_CTL) begin
                ctrl_q.irq_en <= s_axi_wdata[SIM_CTL_IE_BIT];
                ctrl_q.link_en <= s_axi_wdata[SIM_CTL_EN_BIT]; // [R3]
                ctrl_q.addr_low_bits <=
                    s_axi_wdata[SIM_CTL_ID_LSB +: 2]; // [R2]
            end
        end
    end

    // A master byte overrides a software write in the same cycle
    always_ff @(posedge clk) begin
        if (!resetn) begin
            rx0_q <= SIM_BYTE_RST; // [R7]
            rx1_q <= SIM_BYTE_RST;
        end else if (rx_store) begin
            if (idx_q == 2'h0) rx0_q <= sh_q; // [R8]
            else rx1_q <= sh_q;
        end else if (wr_fire && s_axi_wstrb[0]) begin
            if (wr_idx == SIM_IDX_RX0) rx0_q <= s_axi_wdata[7:0];
            if (wr_idx == SIM_IDX_RX1) rx1_q <= s_axi_wdata[7:0];
        end
    end

    // ==========================================================
    // Event flags and interrupt
    // ==========================================================
    always_comb begin
        flag_set = 7'h00;
        flag_set[SIM_FLG_RX0] = rx_store && idx_q == 2'h0; // [R14]
        flag_set[SIM_FLG_RX1] = rx_store && idx_q == 2'h1; // [R12]
        flag_set[SIM_FLG_RX0_OVF] = flag_set[SIM_FLG_RX0]
            && flags_q[SIM_FLG_RX0]; // [R13] [R17]
        flag_set[SIM_FLG_RX1_OVF] = flag_set[SIM_FLG_RX1]
            && flags_q[SIM_FLG_RX1]; // [R11] [R17]
        flag_set[SIM_FLG_TX0] = tx_done && idx_q == 2'h0; // [R10]
        flag_set[SIM_FLG_TX1] = tx_done && idx_q == 2'h1; // [R9]
        flag_set[SIM_FLG_PEND] = |flag_set[5:0]; // [R15]
        flags_d = flags_q;
        if (wr_fire && s_axi_wstrb[0] && wr_idx == SIM_IDX_FLG) begin
            flags_d = flags_q & s_axi_wdata[6:0]; // [R18] [R20]
        end
        flags_d = flags_d | flag_set; // [R20]
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            flags_q <= SIM_FLG_RST; // [R18]
            irq_q <= 1'b0;
        end else begin
            flags_q <= flags_d;
            irq_q <= flags_q[SIM_FLG_PEND] & ctrl_q.irq_en; // [R16]
        end
    end

    // Open drain: the line is only ever pulled low
    always_ff @(posedge clk) begin
        sda_o <= 1'b0;
    end

    assign sda_oe = sda_oe_q;
    assign irq = irq_q;
    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    // ==========================================================
    // Assertions
    // ==========================================================
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence s_addr_end;
        ctrl_q.link_en && !start_det && !stop_det && st_q == SIM_ADDR
            && scl_fall && bitcnt_q == SIM_BITS_PER_BYTE;
    endsequence

    sequence s_flag_clear(int b);
        wr_fire && s_axi_wstrb[0] && wr_idx == SIM_IDX_FLG
            && !s_axi_wdata[b] && !flag_set[b];
    endsequence

    a_addr_match_ack: assert property ( // [R1] [R2]
        s_addr_end and (sh_q[7:1] == {5'h0B, ctrl_q.addr_low_bits})
        |=> sda_oe_q && st_q == SIM_ADDR_ACK)
        else $error("matching address not acknowledged");

    a_addr_miss_nack: assert property ( // [R19]
        s_addr_end and !addr_hit |=> !sda_oe_q && st_q == SIM_IDLE)
        else $error("foreign address acknowledged");

    a_disable_idle: assert property ( // [R3]
        !ctrl_q.link_en |=> st_q == SIM_IDLE && !sda_oe_q)
        else $error("link active while disabled");

    a_first_tx_bit: assert property ( // [R4]
        ctrl_q.link_en && !start_det && !stop_det
        && st_q == SIM_ADDR_ACK && rw_q && scl_fall
        |=> sda_oe_q == !tx0_q[7] && st_q == SIM_TX)
        else $error("first read byte not from transmit zero");

    a_second_tx_bit: assert property ( // [R5]
        ctrl_q.link_en && !start_det && !stop_det
        && st_q == SIM_TX_NEXT && scl_fall && idx_q == 2'h1
        |=> sda_oe_q == !tx1_q[7])
        else $error("second read byte not from transmit one");

    a_rx0_capture: assert property ( // [R7] [R8] [R14]
        rx_store && idx_q == 2'h0
        |=> rx0_q == $past(sh_q) && flags_q[SIM_FLG_RX0]
        && flags_q[SIM_FLG_PEND])
        else $error("receive zero capture wrong");

    a_rx1_overflow: assert property ( // [R11] [R12] [R17]
        rx_store && idx_q == 2'h1 && flags_q[SIM_FLG_RX1]
        |=> flags_q[SIM_FLG_RX1_OVF] && rx1_q == $past(sh_q))
        else $error("receive one overflow missed");

    a_rx0_overflow: assert property ( // [R13] [R17]
        rx_store && idx_q == 2'h0 && !flags_q[SIM_FLG_RX0]
        && !flags_q[SIM_FLG_RX0_OVF] |=> !flags_q[SIM_FLG_RX0_OVF])
        else $error("spurious receive zero overflow");

    a_tx_done: assert property ( // [R9] [R10] [R15]
        tx_done |=> flags_q[SIM_FLG_PEND]
        && (flags_q[SIM_FLG_TX0] || flags_q[SIM_FLG_TX1]))
        else $error("transmit done flag missed");

    a_pend_clear: assert property ( // [R18] [R20]
        s_flag_clear(SIM_FLG_PEND) |=> !flags_q[SIM_FLG_PEND])
        else $error("pending flag not cleared by zero");

    a_flag_keep: assert property ( // [R20]
        wr_fire && s_axi_wstrb[0] && wr_idx == SIM_IDX_FLG
        && s_axi_wdata[SIM_FLG_RX0] && flags_q[SIM_FLG_RX0]
        |=> flags_q[SIM_FLG_RX0])
        else $error("writing one cleared a flag");

    a_irq_gate: assert property ( // [R16]
        flags_q[SIM_FLG_PEND] && ctrl_q.irq_en |=> irq_q)
        else $error("interrupt not raised");

    a_tx_write: assert property ( // [R6]
        wr_fire && s_axi_wstrb[0] && wr_idx == SIM_IDX_TX1
        |=> tx1_q == $past(s_axi_wdata[7:0]))
        else $error("transmit one write lost");

endmodule // sim_mailbox

// file: testbench/sim_master_model.sv
`timescale 1ns/100ps
// ==========================================================
// Link master model: SCL stands high between frames
// ==========================================================
module sim_master_model (
    input wire logic clk,
    input wire logic sda_in,
    output logic scl,
    output logic sda_rel
);
    logic r;
    initial begin
        scl = 1'h1;
        sda_rel = 1'h1;
    end
    // Whole clocks only, so a bit lasts 120 ns instead of 125 ns
    task automatic q();
        repeat (3) @(posedge clk);
    endtask
    task automatic bit_io(input logic b, output logic s);
        sda_rel <= b;
        q();
        scl <= 1'h1;
        q();
        s = sda_in;
        q();
        scl <= 1'h0;
        q();
    endtask
    task automatic start();
        sda_rel <= 1'h1;
        q();
        scl <= 1'h1;
        q();
        sda_rel <= 1'h0;
        q();
        scl <= 1'h0;
        q();
    endtask
    task automatic stop();
        sda_rel <= 1'h0;
        q();
        scl <= 1'h1;
        q();
        sda_rel <= 1'h1;
        q();
    endtask
    task automatic wbyte(input logic [7:0] d, output logic ack);
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'h1, r);
        ack = ~r;
    endtask
    task automatic rbyte(input logic last, output logic [7:0] d);
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'h1, r);
            d[i] = r;
        end
        bit_io(last, r);
    endtask
endmodule // sim_master_model

// file: testbench/slave_i2c_mailbox_tb_top.sv
`timescale 1ns/100ps
// ==========================================================
// Bench top
// ==========================================================
module slave_i2c_mailbox_tb_top;
    import sim_pkg::*;
    logic clk, resetn, sda_o, sda_oe, irq, scl, sda_rel, sda, ack;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [SIM_ADDR_W-1:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [7:0] b0, b1;
    int error_cnt, checked;
    // Pulled up: low when either side pulls
    assign sda = sda_rel & (~sda_oe | sda_o);
    sim_mailbox sim_mailbox_inst (.clk(clk), .resetn(resetn),
        .scl_pin(scl), .sda_pin(sda), .sda_o(sda_o), .sda_oe(sda_oe),
        .irq(irq), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_araddr(araddr),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp));
    sim_master_model mst (.clk(clk), .sda_in(sda), .scl(scl),
        .sda_rel(sda_rel));
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    initial #300000 begin
        error_cnt++;
        conclude();
    end
    task automatic conclude();
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic axw(input logic [9:0] i, input logic [7:0] v,
            input logic [1:0] er);
        @(posedge clk);
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        awaddr <= {i, 2'h0};
        wdata <= {24'h0, v};
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end while (!bvalid);
        bready <= 1'h0;
        chk({30'h0, bresp}, {30'h0, er});
    endtask
    task automatic axr(input logic [9:0] i, input logic [1:0] er);
        @(posedge clk);
        arvalid <= 1'h1;
        rready <= 1'h1;
        araddr <= {i, 2'h0};
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'h0;
        end while (!rvalid);
        d = rdata;
        rready <= 1'h0;
        chk({30'h0, rresp}, {30'h0, er});
    endtask
    task automatic rdc(input logic [9:0] i, input logic [7:0] e);
        axr(i, SIM_RESP_OKAY);
        chk(d, {24'h0, e});
    endtask
    task automatic mw(input logic [1:0] id, input int n,
            input logic [15:0] x, input logic ea);
        mst.start();
        mst.wbyte({SIM_ADDR_FIXED, id, 1'h0}, ack);
        chk({31'h0, ack}, {31'h0, ea});
        for (int i = 0; i < n; i++) begin
            mst.wbyte(x[15-8*i -: 8], ack);
            chk({31'h0, ack}, 32'h1);
        end
        mst.stop();
    endtask
    initial begin
        {resetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
        {awaddr, araddr, wdata, wstrb} = {24'h0, 32'h0, 4'hF};
        repeat (12) @(posedge clk);
        resetn <= 1'h1;
        for (int i = 0; i < 6; i++) rdc(SIM_IDX_TX0 + 10'(i), 8'h0);
        axr(10'h120, SIM_RESP_SLVERR);
        axw(10'h120, 8'hFF, SIM_RESP_SLVERR);
        mw(2'h2, 0, 16'h0, 1'h0);
        axw(SIM_IDX_CTL, 8'h1A, SIM_RESP_OKAY);
        mw(2'h1, 0, 16'h0, 1'h0);
        rdc(SIM_IDX_FLG, 8'h00);
        $display("test address done");
        mw(2'h2, 2, 16'hA53C, 1'h1);
        rdc(SIM_IDX_RX0, 8'hA5);
        rdc(SIM_IDX_RX1, 8'h3C);
        rdc(SIM_IDX_FLG, 8'h45);
        chk({31'h0, irq}, 32'h1);
        mw(2'h2, 2, 16'h5AC3, 1'h1);
        rdc(SIM_IDX_FLG, 8'h4F);
        axw(SIM_IDX_FLG, 8'hFF, SIM_RESP_OKAY);
        rdc(SIM_IDX_FLG, 8'h4F);
        axw(SIM_IDX_FLG, 8'h40, SIM_RESP_OKAY);
        rdc(SIM_IDX_FLG, 8'h40);
        axw(SIM_IDX_FLG, 8'h00, SIM_RESP_OKAY);
        rdc(SIM_IDX_FLG, 8'h00);
        chk({31'h0, irq}, 32'h0);
        $display("test write done");
        axw(SIM_IDX_TX0, 8'h81, SIM_RESP_OKAY);
        axw(SIM_IDX_TX1, 8'h7E, SIM_RESP_OKAY);
        rdc(SIM_IDX_TX1, 8'h7E);
        wstrb <= 4'hE;
        axw(SIM_IDX_TX1, 8'h55, SIM_RESP_OKAY);
        wstrb <= 4'hF;
        rdc(SIM_IDX_TX1, 8'h7E);
        mst.start();
        mst.wbyte({SIM_ADDR_FIXED, 2'h2, 1'h1}, ack);
        chk({31'h0, ack}, 32'h1);
        mst.rbyte(1'h0, b0);
        mst.rbyte(1'h1, b1);
        mst.stop();
        chk({24'h0, b0}, 32'h81);
        chk({24'h0, b1}, 32'h7E);
        rdc(SIM_IDX_FLG, 8'h70);
        chk({31'h0, irq}, 32'h1);
        axw(SIM_IDX_CTL, 8'h0A, SIM_RESP_OKAY);
        rdc(SIM_IDX_CTL, 8'h0A);
        chk({31'h0, irq}, 32'h0);
        $display("test read done");
        resetn <= 1'h0;
        repeat (4) @(posedge clk);
        resetn <= 1'h1;
        for (int i = 0; i < 6; i++)
            rdc(SIM_IDX_TX0 + 10'(i), 8'h0);
        $display("test reset done");
        conclude();
    end
endmodule // slave_i2c_mailbox_tb_top
